// *** common/cpl_cfg.svh ***
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH

// ----------------------------------------
// Channel and control word layout
// ----------------------------------------
`define CPL_NCH 4
`define CPL_CHAN_MAX 8'h03
`define CPL_CTRL_W 16
`define CPL_BIT_CNT_EN 0
`define CPL_BIT_CLEAR 3
`define CPL_BIT_DIR 7
`define CPL_CODE_LSB 9
`define CPL_CODE_MSB 11
`define CPL_SRC_SW 3'h1
`define CPL_SRC_TRIG 3'h2
`define CPL_SRC_CMP 3'h3
`define CPL_SRC_LATCH 3'h4
`define CPL_INCFG_TRIG 8'h02

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define CPL_OFS_PRELOAD 12'h000
`define CPL_OFS_COMMAND 12'h004
`define CPL_OFS_STATUS 12'h008
`define CPL_OFS_INCFG 12'h00C
`define CPL_OFS_CTRL0 12'h010
`define CPL_OFS_CTRL3 12'h01C
`define CPL_ST_ERR_BIT 4
`define CPL_ST_BUSY_BIT 5
`define CPL_ST_CODE_LSB 8
`define CPL_ERR_NONE 8'h00
`define CPL_ERR_CHAN 8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define CPL_CLK_NS 10
`define CPL_WR_LOW_NS 20
`define CPL_WR_LOW_CYC ((`CPL_WR_LOW_NS + `CPL_CLK_NS - 1) / `CPL_CLK_NS)

`endif

// *** common/cpl_pkg.sv ***
package cpl_pkg;
    typedef logic [2:0] cpl_code_t;
    typedef logic signed [31:0] cpl_word_t;
    typedef enum logic [1:0] {
        CPL_IDLE,
        CPL_STROBE,
        CPL_RECOVER
    } cpl_wr_state_t;
endpackage

// *** common/cpl_if.sv ***
`timescale 1ns/10ps
`include "cpl_cfg.svh"
interface cpl_if;
    logic wr_n;
    logic [1:0] wr_chan;
    cpl_pkg::cpl_word_t wr_data;
    logic [`CPL_NCH-1:0][`CPL_CTRL_W-1:0] ctrl_word;
    logic [`CPL_NCH-1:0][7:0] in_cfg;
    logic [`CPL_NCH-1:0] done;

    modport dev (
        input wr_n,
        input wr_chan,
        input wr_data,
        input ctrl_word,
        input in_cfg,
        output done
    );
    modport host (
        output wr_n,
        output wr_chan,
        output wr_data,
        output ctrl_word,
        output in_cfg,
        input done
    );
endinterface

// *** rtl/cpl_sync.sv ***
`timescale 1ns/10ps
module cpl_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pin side
    input wire logic [W-1:0] pin,
    // Clean side
    output logic [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] agree;

    // A bit only moves once the second and third stages match.
    assign agree = ~(s2 ^ s3);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= (agree & s3) | (~agree & level);
        end
    end
endmodule

// *** rtl/cpl_device.sv ***
`timescale 1ns/10ps
`include "cpl_cfg.svh"
module cpl_device (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link to the host end
    cpl_if.dev link,
    // Field terminals
    input wire logic [`CPL_NCH-1:0] channel_trigger_input,
    // Counting logic on the same clock
    input wire logic [`CPL_NCH-1:0] compare_equal_flag,
    input wire logic [`CPL_NCH-1:0] count_step,
    input wire logic [`CPL_NCH-1:0] count_down,
    // Results
    output logic [`CPL_NCH-1:0][31:0] count_value,
    output logic [`CPL_NCH-1:0][31:0] latch_value,
    output logic [`CPL_NCH-1:0] load_pulse
);
    // ----------------------------------------
    // Strobe and input conditioning
    // ----------------------------------------
    logic wr_n_d;
    logic wr_edge;
    logic [`CPL_NCH-1:0] trig_level;
    logic [`CPL_NCH-1:0] trig_d;
    logic [`CPL_NCH-1:0] trig_rise;
    logic [`CPL_NCH-1:0] cmp_d;
    logic [`CPL_NCH-1:0] cmp_rise;

    // The strobe comes from logic on this clock, so no synchroniser.
    assign wr_edge = wr_n_d & ~link.wr_n;

    // Field terminals are asynchronous and may bounce.
    cpl_sync #(
        .W(`CPL_NCH)
    ) u_trig_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(channel_trigger_input),
        .level(trig_level)
    );

    assign trig_rise = trig_level & ~trig_d;
    // A held compare level would pin the count, so only its arrival loads.
    assign cmp_rise = compare_equal_flag & ~cmp_d;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_n_d <= 1'b1;
            trig_d <= '0;
            cmp_d <= '0;
        end else begin
            wr_n_d <= link.wr_n;
            trig_d <= trig_level;
            cmp_d <= compare_equal_flag;
        end
    end

    // ----------------------------------------
    // Per-channel preload, count and latch
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CPL_NCH; g++) begin : gen_ch
            cpl_pkg::cpl_code_t code;
            cpl_pkg::cpl_word_t preload_word;
            cpl_pkg::cpl_word_t count;
            cpl_pkg::cpl_word_t next_preload_word;
            cpl_pkg::cpl_word_t next_count;
            cpl_pkg::cpl_word_t stepped;
            logic sel;
            logic wr_here;
            logic trig_armed;
            logic mode_sw;
            logic mode_trig;
            logic mode_cmp;
            logic mode_latch;
            logic load;
            logic cnt_en;
            logic clear;
            logic dir_down;
            logic next_done;

            // Only a two-bit select exists, so channels above three cannot be hit.
            assign sel = (link.wr_chan == 2'(g));
            assign wr_here = wr_edge & sel;
            assign code = link.ctrl_word[g][`CPL_CODE_MSB:`CPL_CODE_LSB];

            assign mode_sw = (code == `CPL_SRC_SW);
            assign mode_trig = (code == `CPL_SRC_TRIG);
            assign mode_cmp = (code == `CPL_SRC_CMP);
            assign mode_latch = (code == `CPL_SRC_LATCH);
            // A terminal not set up for triggering must not fire a load.
            assign trig_armed = (link.in_cfg[g] == `CPL_INCFG_TRIG);

            // One code per channel, so at most one source is live.
            assign load = (mode_sw & wr_here)
                | (mode_trig & trig_armed & trig_rise[g])
                | (mode_cmp & cmp_rise[g]);

            assign cnt_en = link.ctrl_word[g][`CPL_BIT_CNT_EN];
            assign clear = link.ctrl_word[g][`CPL_BIT_CLEAR];
            assign dir_down = count_down[g] ^ link.ctrl_word[g][`CPL_BIT_DIR];

            // Software mode uses the word arriving with the strobe itself.
            assign next_preload_word = wr_here ? link.wr_data : preload_word;
            assign stepped = dir_down ? (count - 32'sh1) : (count + 32'sh1);
            assign next_count = load ? next_preload_word :
                clear ? 32'sh0 :
                (cnt_en & count_step[g]) ? stepped : count;

            // Set wins over the clear that a fresh host write causes.
            assign next_done = (load & (next_preload_word != 32'sh0))
                | (link.done[g] & ~wr_here);

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    preload_word <= 32'sh0;
                    count <= 32'sh0;
                    latch_value[g] <= 32'h0;
                    link.done[g] <= 1'b0;
                    load_pulse[g] <= 1'b0;
                end else begin
                    preload_word <= next_preload_word;
                    count <= next_count;
                    link.done[g] <= next_done;
                    load_pulse[g] <= load;
                    if (mode_latch & trig_armed & trig_rise[g]) begin
                        latch_value[g] <= count;
                    end
                end
            end

            assign count_value[g] = count;
        end
    endgenerate
endmodule

// *** rtl/cpl_host.sv ***
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "cpl_cfg.svh"
module cpl_host #(
    parameter int WR_LOW_CYC = `CPL_WR_LOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status
    output logic [7:0] error_code_out,
    // Link to the device end
    cpl_if.host link
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    cpl_pkg::cpl_wr_state_t state;
    cpl_pkg::cpl_word_t preload_word;
    logic [7:0] cnt;
    logic acc;
    logic wr;
    logic hit_pre;
    logic hit_cmd;
    logic hit_st;
    logic hit_cfg;
    logic hit_ctl;
    logic mapped;
    logic busy;
    logic cmd_ok;
    logic [1:0] ctl_idx;
    logic [31:0] status;
    logic [31:0] rd_mux;

    assign acc = psel & penable;
    assign hit_pre = (paddr == `CPL_OFS_PRELOAD);
    assign hit_cmd = (paddr == `CPL_OFS_COMMAND);
    assign hit_st = (paddr == `CPL_OFS_STATUS);
    assign hit_cfg = (paddr == `CPL_OFS_INCFG);
    assign hit_ctl = (paddr >= `CPL_OFS_CTRL0) && (paddr <= `CPL_OFS_CTRL3) && (paddr[1:0] == 2'h0);
    assign ctl_idx = paddr[3:2];
    assign mapped = hit_pre | hit_cmd | hit_st | hit_cfg | hit_ctl;
    assign busy = (state != cpl_pkg::CPL_IDLE);
    // A command waits while a strobe or its recovery cycle is still running, which stalls the bus.
    assign pready = ~(hit_cmd & pwrite & busy);
    assign wr = acc & pready & pwrite;
    assign pslverr = acc & ~mapped;
    assign cmd_ok = (pwdata[7:0] <= `CPL_CHAN_MAX);

    assign status = {16'h0, error_code_out, 2'h0, busy, (error_code_out != `CPL_ERR_NONE), link.done};
    assign rd_mux = hit_pre ? preload_word :
        hit_cmd ? {30'h0, link.wr_chan} :
        hit_st ? status :
        hit_cfg ? link.in_cfg :
        hit_ctl ? {16'h0, link.ctrl_word[ctl_idx]} : 32'h0;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            preload_word <= 32'sh0;
            link.in_cfg <= '0;
            link.ctrl_word <= '0;
            error_code_out <= `CPL_ERR_NONE;
            prdata <= 32'h0;
        end else begin
            // Read data is caught in the setup cycle, so it stands through the access phase.
            if (psel & ~penable & ~pwrite) begin
                prdata <= rd_mux;
            end
            if (wr & hit_pre) begin
                preload_word <= pwdata;
            end
            if (wr & hit_cfg) begin
                link.in_cfg <= pwdata;
            end
            if (wr & hit_ctl) begin
                link.ctrl_word[ctl_idx] <= pwdata[15:0];
            end
            if (wr & hit_cmd) begin
                error_code_out <= cmd_ok ? `CPL_ERR_NONE : `CPL_ERR_CHAN;
            end
        end
    end

    // ----------------------------------------
    // Write strobe sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= cpl_pkg::CPL_IDLE;
            cnt <= 8'h0;
            link.wr_n <= 1'b1;
            link.wr_chan <= 2'h0;
            link.wr_data <= 32'sh0;
        end else begin
            unique case (state)
                cpl_pkg::CPL_IDLE: begin
                    if (wr & hit_cmd & cmd_ok) begin
                        link.wr_chan <= pwdata[1:0];
                        link.wr_data <= preload_word;
                        link.wr_n <= 1'b0;
                        cnt <= 8'(WR_LOW_CYC - 1);
                        state <= cpl_pkg::CPL_STROBE;
                    end
                end
                cpl_pkg::CPL_STROBE: begin
                    if (cnt == 8'h0) begin
                        link.wr_n <= 1'b1;
                        state <= cpl_pkg::CPL_RECOVER;
                    end else begin
                        cnt <= cnt - 8'h1;
                    end
                end
                cpl_pkg::CPL_RECOVER: begin
                    state <= cpl_pkg::CPL_IDLE;
                end
            endcase
        end
    end
endmodule

// *** test/cpl_monitor.sv ***
`timescale 1ns/10ps
module cpl_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link signals
    input wire logic wr_n,
    input wire logic [1:0] wr_chan,
    input wire cpl_pkg::cpl_word_t wr_data,
    input wire logic [3:0][15:0] ctrl_word,
    input wire logic [3:0][7:0] in_cfg,
    input wire logic [3:0] done
);
    // ----------------------------------------
    // Link checks.
    // ----------------------------------------
    wire [2:0] code = ctrl_word[wr_chan][11:9];
    wire sw = code == 3'h1;
    wire [3:0] sel = 4'h1 << wr_chan;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_fall;
        $fell(wr_n);
    endsequence
    sequence s_low2;
        !wr_n [*2] ##1 wr_n;
    endsequence
    AST_STROBE_LEN: assert property (s_fall |-> s_low2)
        else $error("strobe length wrong");
    AST_HOLD: assert property (!wr_n && !$past(wr_n) |-> $stable(wr_data) && $stable(wr_chan))
        else $error("strobe data moved");
    AST_SW_DONE: assert property ($fell(wr_n) && sw && wr_data != 0 |=> done[wr_chan] [*2])
        else $error("no done after load");
    AST_ZERO: assert property ($fell(wr_n) && wr_data == 0 |=> !done[wr_chan])
        else $error("done on zero word");
    AST_CODE: assert property ($fell(wr_n) && !sw |=> !done[wr_chan])
        else $error("done without software code");
    AST_STICKY: assert property (wr_n |=> (~done & $past(done)) == 4'h0)
        else $error("done dropped");
    AST_OTHER: assert property ($fell(wr_n) |=> ((done ^ $past(done)) & ~sel) == 4'h0)
        else $error("other channel done moved");
    AST_RST: assert property ($rose(resetn) |-> wr_n)
        else $error("strobe active at reset");
endmodule

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic clk = 0;
    logic resetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, se;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0] trig = 4'h0, cmp = 4'h0, step = 4'h0, down = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [7:0] err;
    wire [3:0][31:0] cnt, lat;
    wire [3:0] lp;
    int failures = 0, check_count = 0;
    cpl_if lnk();
    cpl_host i_cpl_host (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .error_code_out(err), .link(lnk));
    cpl_device i_cpl_device (.clk(clk), .resetn(resetn), .link(lnk), .channel_trigger_input(trig),
        .compare_equal_flag(cmp), .count_step(step), .count_down(down), .count_value(cnt),
        .latch_value(lat), .load_pulse(lp));
    cpl_monitor i_cpl_monitor (.clk(clk), .resetn(resetn), .wr_n(lnk.wr_n), .wr_chan(lnk.wr_chan),
        .wr_data(lnk.wr_data), .ctrl_word(lnk.ctrl_word), .in_cfg(lnk.in_cfg), .done(lnk.done));
    initial forever #5 clk = ~clk;
    // ----------------------------------------
    // Tasks.
    // ----------------------------------------
    task stop_test;
        $display("Checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task fail_to;
        failures++;
        $display("Error t=%0t wait timed out", $time);
        stop_test();
    endtask
    // A command write may stall while a strobe runs, so pready is polled.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) fail_to();
        se = pslverr;
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task wait_lp(input int ch);
        int n;
        n = 0;
        while (lp[ch] !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (lp[ch] !== 1'b1) fail_to();
    endtask
    // Status is caught in the setup cycle, so it is polled until busy has cleared.
    task idle;
        int n;
        n = 0;
        do begin
            apb(0, 12'h008, 0);
            n++;
        end while (rd[5] !== 1'b0 && n < 9);
        if (rd[5] !== 1'b0) fail_to();
    endtask
    // ----------------------------------------
    // Sequence.
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        apb(0, 12'h008, 0);
        chk(rd, 32'h0);
        apb(1, 12'h010, 32'h200);
        apb(1, 12'h000, 32'hFFFFD8F0);
        apb(1, 12'h004, 0);
        wait_lp(0);
        chk(cnt[0], 32'hFFFFD8F0);
        idle();
        chk(rd, 32'h1);
        apb(1, 12'h014, 32'h200);
        apb(1, 12'h000, 0);
        apb(1, 12'h004, 1);
        wait_lp(1);
        idle();
        chk(rd, 32'h1);
        apb(1, 12'h004, 4);
        chk({24'h0, err}, 32'h1);
        apb(0, 12'h008, 0);
        chk(rd, 32'h111);
        apb(0, 12'h100, 0);
        chk({31'h0, se}, 32'h1);
        $display("test software done");
        // Counting stays enabled so a second trigger must undo a step.
        apb(1, 12'h018, 32'h401);
        apb(1, 12'h00C, 32'h20000);
        apb(1, 12'h000, 32'h12345678);
        apb(1, 12'h004, 2);
        idle();
        chk(cnt[2], 32'h0);
        trig <= 4'h4;
        wait_lp(2);
        chk(cnt[2], 32'h12345678);
        trig <= 4'h0;
        repeat (6) @(posedge clk);
        step <= 4'h4;
        @(posedge clk);
        step <= 4'h0;
        @(posedge clk);
        chk(cnt[2], 32'h12345679);
        trig <= 4'h4;
        wait_lp(2);
        chk(cnt[2], 32'h12345678);
        $display("test trigger done");
        apb(1, 12'h01C, 32'h601);
        apb(1, 12'h000, 32'h80000000);
        apb(1, 12'h004, 3);
        idle();
        cmp <= 4'h8;
        step <= 4'h8;
        @(posedge clk);
        cmp <= 4'h0;
        step <= 4'h0;
        wait_lp(3);
        chk(cnt[3], 32'h80000000);
        apb(0, 12'h008, 0);
        chk(rd, 32'hD);
        $display("test compare done");
        apb(1, 12'h014, 32'h801);
        apb(1, 12'h00C, 32'h20200);
        step <= 4'h2;
        repeat (3) @(posedge clk);
        step <= 4'h0;
        trig <= 4'h2;
        repeat (8) @(posedge clk);
        chk(lat[1], 32'h3);
        chk(cnt[1], 32'h3);
        $display("test latch done");
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_to();
    end
endmodule
